//--- rtl/stp_pkg.sv
// Package of register map, field layout and mode encodings for the standard timer
package stp_pkg;

    // Register word indexes (byte address is four times the index)
    localparam logic [2:0] REG_CTRL0   = 3'h0;
    localparam logic [2:0] REG_CTRL1   = 3'h1;
    localparam logic [2:0] REG_CNT_LO  = 3'h2;
    localparam logic [2:0] REG_CNT_HI  = 3'h3;
    localparam logic [2:0] REG_CMPA_LO = 3'h4;
    localparam logic [2:0] REG_CMPA_HI = 3'h5;
    localparam logic [2:0] REG_FLAGS   = 3'h6;

    // Control register zero fields
    localparam int unsigned RUN_BIT     = 3;
    localparam int unsigned COARSE_LSB  = 0;
    // Control register one fields
    localparam int unsigned MODE_LSB    = 6;
    localparam int unsigned FN_LSB      = 4;
    localparam int unsigned LEVEL_BIT   = 3;
    localparam int unsigned INVERT_BIT  = 2;
    localparam int unsigned SWAP_BIT    = 1;
    localparam int unsigned CLRSEL_BIT  = 0;
    // Flag register fields
    localparam int unsigned FLAG_A_BIT  = 0;
    localparam int unsigned FLAG_P_BIT  = 1;

    // Reset values
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [2:0]  COARSE_RST  = 3'h0;
    localparam logic [9:0]  CMPA_RST    = 10'h000;
    localparam logic [9:0]  CNT_RST     = 10'h000;

    // Counter figures
    localparam logic [9:0]  CNT_MAX     = 10'h3ff;
    localparam logic [10:0] FULL_COUNT  = 11'h400;

    // Timer clock is core clock divided by this count
    localparam int unsigned TICK_DIV    = 4;
    localparam int unsigned TICK_W      = $clog2(TICK_DIV);

    typedef enum logic [1:0] {
        MODE_CMP = 2'b00,
        MODE_CAP = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TMR = 2'b11
    } stp_mode_t;

    // Output function codes, compare mode and pwm mode
    localparam logic [1:0] FN_NONE   = 2'b00;
    localparam logic [1:0] FN_LOW    = 2'b01;
    localparam logic [1:0] FN_HIGH   = 2'b10;
    localparam logic [1:0] FN_TOGGLE = 2'b11;
    localparam logic [1:0] FN_INACT  = 2'b00;
    localparam logic [1:0] FN_ACT    = 2'b01;
    localparam logic [1:0] FN_PWM    = 2'b10;
    localparam logic [1:0] FN_PULSE  = 2'b11;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } stp_bus_t;

    // Coarse value in timer clocks, zero standing for a full count
    function automatic logic [10:0] stp_coarse_len(input logic [2:0] rp);
        stp_coarse_len = (rp == 3'h0) ? FULL_COUNT : {1'b0, rp, 7'h00};
    endfunction

endpackage

//--- rtl/stp_tick_if.sv
// Interface carrying timer tick and external pin edge between timer modules
`timescale 1ns/1ns
interface stp_tick_if;
    logic tick;
    logic ext_rise;
    modport src (output tick, output ext_rise);
    modport dst (input tick, input ext_rise);
endinterface

//--- rtl/stp_tick_gen.sv
// Timer clock enable divider and external clock pin synchroniser
`timescale 1ns/1ns
module stp_tick_gen (
    // Clock and reset
    input  wire logic     core_clk,
    input  wire logic     srst,
    // External clock pin
    input  wire logic     ext_clock_pin,
    // Tick and edge towards the timer
    stp_tick_if.src       tk
);
    import stp_pkg::*;

    logic [stp_pkg::TICK_W-1:0] div_q;
    logic [stp_pkg::TICK_W-1:0] div_d;
    logic                       tick_q;
    logic                       tick_d;
    logic [2:0]                 sync_q;
    logic [2:0]                 sync_d;
    logic                       stable_q;
    logic                       stable_d;
    logic                       rise_q;
    logic                       rise_d;

    always_comb begin
        tick_d   = (div_q == TICK_W'(TICK_DIV - 1));
        div_d    = tick_d ? '0 : div_q + TICK_W'(1);
        sync_d   = {sync_q[1:0], ext_clock_pin};
        // Only the two settled stages are compared; the first stage may be metastable
        stable_d = (sync_q[1] == sync_q[2]) ? sync_q[1] : stable_q;
        rise_d   = (sync_q[1] == sync_q[2]) && sync_q[1] && !stable_q;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            div_q    <= '0;
            tick_q   <= 1'b0;
            sync_q   <= 3'h0;
            stable_q <= 1'b0;
            rise_q   <= 1'b0;
        end else begin
            div_q    <= div_d;
            tick_q   <= tick_d;
            sync_q   <= sync_d;
            stable_q <= stable_d;
            rise_q   <= rise_d;
        end
    end

    assign tk.tick     = tick_q;
    assign tk.ext_rise = rise_q;

endmodule

//--- rtl/stp_timer_top.sv
// Standard timer with compare match, timer, pwm and single pulse modes
// Function
// - Compare mode, output sits at the level bit before any match.
// - PWM mode, level bit chooses active low or active high waveform.
// - Single pulse mode, output takes the level bit when run rises.
// - Invert bit inverts the output pin; neither bit acts in timer mode.
// - Swap bit exchanges period and duty roles of coarse and compare-A values.
// - Clear select: 1 clears on A match or overflow, 0 on P match.
// - Counter readable as low byte and two high bits, upper bits zero.
// - Compare-A value held in writable low byte and two high bits.
// - Mode 00 is compare match; counter clears by overflow, A or P.
// - Compare mode, clear select 0, raises both A and P flags.
// - Compare mode, clear select 1, raises only the A flag.
// - Zero compare-A overflows at 3FF and raises no A flag.
// - Compare mode, pin changes only on A match; function 00 never.
// - Run rising in compare mode reloads output with the level bit.
// - Mode 11 counts and flags like compare mode, pin not driven.
// - PWM needs mode 10 and function 10 for the waveform.
// - PWM mode raises A and P flags on their matches.
// - Swap 0: period is 128 times coarse, 000 meaning 1024; duty compare-A.
// - Swap 1: period is compare-A; duty 128 times coarse, 000 meaning 1024.
// - Duty not below period holds the output at its active level.
// - PWM counting continues while function forces a fixed level.
// - Single pulse starts on run rising, by software or external pin.
// - Pulse trailing edge when run clears by software or A match.
// - Pulse A match clears run, flags; coarse unused; no restart clear.
// - Run rising clears counter; run falling stops and holds it.
// - Compare A match action: none, low, high or toggle.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module stp_timer_top (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Avalon-MM slave
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // External clock pin
    input  wire logic        ext_clock_pin,
    // Timer output pin
    output logic             timer_out,
    output logic             timer_out_oe,
    // Flag requests
    output logic             compare_a_req,
    output logic             compare_p_req
);
    import stp_pkg::*;

    stp_tick_if tk ();

    stp_tick_gen u_tick (
        .core_clk      (core_clk),
        .srst          (srst),
        .ext_clock_pin (ext_clock_pin),
        .tk            (tk)
    );

    // Bus state
    stp_bus_t    st_q;
    stp_bus_t    st_d;
    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    // Register state
    logic        run_q;
    logic        run_d;
    logic        run_prev_q;
    logic [2:0]  coarse_q;
    logic [2:0]  coarse_d;
    logic [7:0]  ctrl1_q;
    logic [7:0]  ctrl1_d;
    logic [9:0]  cmpa_q;
    logic [9:0]  cmpa_d;
    logic        fa_q;
    logic        fa_d;
    logic        fp_q;
    logic        fp_d;
    // Timer state
    logic [9:0]  cnt_q;
    logic [9:0]  cnt_d;
    logic        out_q;
    logic        out_d;
    logic        pin_q;
    logic        pin_d;
    logic        oe_q;
    logic        oe_d;

    // Decoded controls
    stp_mode_t   mode;
    logic [1:0]  fn;
    logic        lvl;
    logic        inv;
    logic        swap;
    logic        clrsel;
    logic        pulse_mode;
    logic        run_rise;
    logic        step;
    logic [10:0] cnt_inc;
    logic [10:0] len_p;
    logic [10:0] len_a;
    logic [10:0] period;
    logic [10:0] duty;
    logic        hit_a;
    logic        hit_p;
    logic        ev_a;
    logic        ev_p;
    logic        clear;
    logic        active;
    logic        wr_go;
    logic        wr_ctrl0;
    logic        wr_flags;
    logic [31:0] rd_mux;

    always_comb begin
        mode       = stp_mode_t'(ctrl1_q[MODE_LSB +: 2]);
        fn         = ctrl1_q[FN_LSB +: 2];
        lvl        = ctrl1_q[LEVEL_BIT];
        inv        = ctrl1_q[INVERT_BIT];
        swap       = ctrl1_q[SWAP_BIT];
        clrsel     = ctrl1_q[CLRSEL_BIT];
        pulse_mode = (mode == MODE_PWM) && (fn == FN_PULSE);
        run_rise   = run_q && !run_prev_q;
        // Capture mode is not built, so the counter rests there
        step       = tk.tick && run_q && !run_rise && (mode != MODE_CAP);
        cnt_inc    = {1'b0, cnt_q} + 11'h001;
        len_p      = stp_coarse_len(coarse_q);
        len_a      = (cmpa_q == 10'h000) ? FULL_COUNT : {1'b0, cmpa_q};
        period     = swap ? len_a : len_p;
        duty       = swap ? len_p : {1'b0, cmpa_q};
        hit_a      = (cmpa_q != 10'h000) && (cnt_inc == {1'b0, cmpa_q});
        hit_p      = (cnt_inc == len_p);
        ev_a       = 1'b0;
        ev_p       = 1'b0;
        clear      = 1'b0;
        if (step) begin
            case (mode)
                MODE_CMP, MODE_TMR: begin
                    ev_a  = hit_a;
                    ev_p  = hit_p && !clrsel;
                    // Zero coarse makes the P match land on the overflow
                    clear = clrsel ? (hit_a || cnt_q == CNT_MAX) : hit_p;
                end
                MODE_PWM: begin
                    if (pulse_mode) begin
                        ev_a = hit_a;
                    end else begin
                        ev_a  = hit_a;
                        ev_p  = hit_p;
                        clear = (cnt_inc == period);
                    end
                end
                default: begin
                    clear = 1'b0;
                end
            endcase
        end
        active = (duty >= period) || ({1'b0, cnt_q} < duty);
    end

    // Bus slave
    always_comb begin
        wr_go    = (st_q == BUS_ACK) && avs_write && avs_byteenable[0];
        wr_ctrl0 = wr_go && (avs_address == REG_CTRL0);
        wr_flags = wr_go && (avs_address == REG_FLAGS);
        case (avs_address)
            REG_CTRL0:   rd_mux = {24'h0, 4'h0, run_q, coarse_q};
            REG_CTRL1:   rd_mux = {24'h0, ctrl1_q};
            REG_CNT_LO:  rd_mux = {24'h0, cnt_q[7:0]};
            REG_CNT_HI:  rd_mux = {30'h0, cnt_q[9:8]};
            REG_CMPA_LO: rd_mux = {24'h0, cmpa_q[7:0]};
            REG_CMPA_HI: rd_mux = {30'h0, cmpa_q[9:8]};
            REG_FLAGS:   rd_mux = {30'h0, fp_q, fa_q};
            default:     rd_mux = 32'h0;
        endcase
        st_d    = ((st_q == BUS_IDLE) && (avs_read || avs_write)) ? BUS_ACK : BUS_IDLE;
        wait_d  = (st_d != BUS_ACK);
        rdata_d = ((st_d == BUS_ACK) && avs_read) ? rd_mux : rdata_q;
    end

    // Registers written by software and by hardware events
    always_comb begin
        coarse_d = coarse_q;
        ctrl1_d  = ctrl1_q;
        cmpa_d   = cmpa_q;
        run_d    = run_q;
        if (wr_ctrl0) begin
            run_d    = avs_writedata[RUN_BIT];
            coarse_d = avs_writedata[COARSE_LSB +: 3];
        end else if (pulse_mode && ev_a) begin
            run_d = 1'b0;
        end else if (pulse_mode && tk.ext_rise) begin
            run_d = 1'b1;
        end
        if (wr_go && avs_address == REG_CTRL1) begin
            ctrl1_d = avs_writedata[7:0];
        end
        if (wr_go && avs_address == REG_CMPA_LO) begin
            cmpa_d[7:0] = avs_writedata[7:0];
        end
        if (wr_go && avs_address == REG_CMPA_HI) begin
            cmpa_d[9:8] = avs_writedata[1:0];
        end
        // Set wins over a clear in the same cycle
        fa_d = ev_a || (fa_q && !(wr_flags && avs_writedata[FLAG_A_BIT]));
        fp_d = ev_p || (fp_q && !(wr_flags && avs_writedata[FLAG_P_BIT]));
    end

    // Counter and output pin
    always_comb begin
        cnt_d = cnt_q;
        if (run_rise) begin
            cnt_d = CNT_RST;
        end else if (step) begin
            cnt_d = clear ? CNT_RST : cnt_inc[9:0];
        end
        out_d = out_q;
        if (run_rise) begin
            out_d = lvl;
        end else if (ev_a && mode == MODE_CMP) begin
            case (fn)
                FN_NONE:   out_d = out_q;
                FN_LOW:    out_d = 1'b0;
                FN_HIGH:   out_d = 1'b1;
                FN_TOGGLE: out_d = !out_q;
                default:   out_d = out_q;
            endcase
        end
        pin_d = 1'b0;
        oe_d  = 1'b0;
        case (mode)
            MODE_CMP: begin
                pin_d = out_q ^ inv;
                oe_d  = 1'b1;
            end
            MODE_PWM: begin
                oe_d = 1'b1;
                case (fn)
                    FN_INACT: pin_d = !lvl ^ inv;
                    FN_ACT:   pin_d = lvl ^ inv;
                    FN_PWM:   pin_d = (active ? lvl : !lvl) ^ inv;
                    FN_PULSE: pin_d = (run_q ? lvl : !lvl) ^ inv;
                    default:  pin_d = 1'b0;
                endcase
            end
            default: begin
                // Timer and capture modes leave the pin to other functions
                pin_d = 1'b0;
                oe_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q       <= BUS_IDLE;
            wait_q     <= 1'b1;
            rdata_q    <= 32'h0;
            run_q      <= 1'b0;
            run_prev_q <= 1'b0;
            coarse_q   <= COARSE_RST;
            ctrl1_q    <= CTRL_RST;
            cmpa_q     <= CMPA_RST;
            fa_q       <= 1'b0;
            fp_q       <= 1'b0;
            cnt_q      <= CNT_RST;
            out_q      <= 1'b0;
            pin_q      <= 1'b0;
            oe_q       <= 1'b0;
        end else begin
            st_q       <= st_d;
            wait_q     <= wait_d;
            rdata_q    <= rdata_d;
            run_q      <= run_d;
            run_prev_q <= run_q;
            coarse_q   <= coarse_d;
            ctrl1_q    <= ctrl1_d;
            cmpa_q     <= cmpa_d;
            fa_q       <= fa_d;
            fp_q       <= fp_d;
            cnt_q      <= cnt_d;
            out_q      <= out_d;
            pin_q      <= pin_d;
            oe_q       <= oe_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign timer_out       = pin_q;
    assign timer_out_oe    = oe_q;
    assign compare_a_req   = fa_q;
    assign compare_p_req   = fp_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_flag_sticky: assert property (fa_q && !(wr_flags && avs_writedata[FLAG_A_BIT])
        |=> fa_q)
        else $error("compare A flag lost without a clear");
    a_run_rise_clear: assert property ($rose(run_q) |=> cnt_q == CNT_RST)
        else $error("counter not cleared after run rose");
    a_stop_hold: assert property (!run_q |=> $stable(cnt_q))
        else $error("counter moved while stopped");
    a_no_p_flag: assert property ((mode == MODE_CMP) && clrsel |-> !ev_p)
        else $error("P flag raised with clear select high");
    a_zero_cmpa: assert property ((cmpa_q == 10'h000) |-> !ev_a)
        else $error("A flag raised with zero compare value");
    a_tmr_no_pin: assert property ((mode == MODE_TMR) |=> !oe_q)
        else $error("pin driven in timer mode");
    a_cmp_init: assert property ((mode == MODE_CMP) && run_rise |=> out_q == $past(lvl))
        else $error("output not reloaded on run rising");
    // Equality binds tighter than xor, so the inactive level is grouped on purpose
    a_pulse_end: assert property (pulse_mode && ev_a && !wr_ctrl0
        |=> !run_q ##1 pin_q == (!lvl ^ inv))
        else $error("single pulse did not end on A match");
    a_pwm_full: assert property ((mode == MODE_PWM) && (fn == FN_PWM) && (duty >= period)
        |=> pin_q == $past(lvl ^ inv))
        else $error("full duty not held at active level");
    a_cmp_pin: assert property ((mode == MODE_CMP) |=> pin_q == $past(out_q ^ inv))
        else $error("compare pin not following level and invert");
    a_bus_answer: assert property ((avs_read || avs_write) && wait_q |-> ##[1:2] !wait_q)
        else $error("bus request not answered");

endmodule

//--- tb/test_standard_timer_pwm_compare.sv
// Self-checking testbench for the standard timer block
`timescale 1ns/1ns
module test_standard_timer_pwm_compare;
    import stp_pkg::*;

    logic        core_clk;
    logic        srst;
    logic [2:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ext_clock_pin;
    logic        timer_out;
    logic        timer_out_oe;
    logic        compare_a_req;
    logic        compare_p_req;
    logic [31:0] rdata;
    int          fails;
    int          compares;

    stp_timer_top dut_u (
        .core_clk        (core_clk),
        .srst            (srst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .ext_clock_pin   (ext_clock_pin),
        .timer_out       (timer_out),
        .timer_out_oe    (timer_out_oe),
        .compare_a_req   (compare_a_req),
        .compare_p_req   (compare_p_req)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkb(input string what, input logic exp, input logic got);
        chk(what, 32'(exp), 32'(got));
    endtask

    task automatic give_up(input string what);
        fails++;
        $display("[ERR] %s expected an answer seen none", what);
        print_verdict();
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        avs_address    <= idx;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= be;
        avs_write      <= w;
        avs_read       <= ~w;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) give_up("bus answer");
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // Idle edge so the next request is not raised in this time step
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask

    task automatic rdchk(input logic [2:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00, 4'hf);
        chk(what, {24'h0, exp}, rdata);
    endtask

    task automatic wait_flag(input logic p, input int bound);
        int n;
        n = 0;
        while (((p ? compare_p_req : compare_a_req) !== 1'b1) && n < bound) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= bound) give_up(p ? "flag p" : "flag a");
    endtask

    // Stop, program, clear flags, then raise run so the counter restarts from zero
    task automatic cfg(input logic [7:0] c1, input logic [2:0] rp, input logic [9:0] a);
        wr(REG_CTRL0, {5'h00, rp});
        wr(REG_CTRL1, c1);
        wr(REG_CMPA_LO, a[7:0]);
        wr(REG_CMPA_HI, {6'h00, a[9:8]});
        wr(REG_FLAGS, 8'h03);
        wr(REG_CTRL0, {5'h01, rp});
    endtask

    task automatic measure(output int hi, output int lo);
        int n;
        n = 0;
        hi = 0;
        lo = 0;
        while (timer_out !== 1'b0 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
        while (timer_out !== 1'b1 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
        while (timer_out === 1'b1 && hi < 5000) begin
            @(posedge core_clk);
            hi++;
        end
        while (timer_out === 1'b0 && lo < 5000) begin
            @(posedge core_clk);
            lo++;
        end
        if (n >= 5000 || hi >= 5000 || lo >= 5000) give_up("pwm edge");
    endtask

    task automatic s_regs;
        for (int i = 0; i < 8; i++) begin
            rdchk(3'(i), 8'h00, "reset value");
        end
        wr(REG_CMPA_LO, 8'hff);
        wr(REG_CMPA_HI, 8'hff);
        rdchk(REG_CMPA_LO, 8'hff, "cmpa low");
        rdchk(REG_CMPA_HI, 8'h03, "cmpa high");
        bus(1'b1, REG_CMPA_LO, 8'h12, 4'h0);
        rdchk(REG_CMPA_LO, 8'hff, "cmpa no enable");
        wr(REG_CNT_LO, 8'h55);
        rdchk(REG_CNT_LO, 8'h00, "count read only");
        wr(3'h7, 8'h5a);
        rdchk(3'h7, 8'h00, "unmapped");
    endtask

    // Every output function code with both starting levels
    task automatic s_cmp_fn;
        logic [1:0] fn;
        logic       lv;
        logic       ex;
        for (int i = 0; i < 8; i++) begin
            fn = 2'(i >> 1);
            lv = i[0];
            ex = (fn == FN_NONE) ? lv : (fn == FN_LOW) ? 1'b0 : (fn == FN_HIGH) ? 1'b1 : ~lv;
            cfg({MODE_CMP, fn, lv, 3'b001}, 3'h1, 10'd200);
            wait_cyc(2);
            chkb("pin before match", lv, timer_out);
            chkb("pin enable", 1'b1, timer_out_oe);
            wait_flag(1'b0, 1000);
            wait_cyc(2);
            chkb("pin after match", ex, timer_out);
            chkb("flag p", 1'b0, compare_p_req);
        end
    endtask

    task automatic s_cmp_p;
        cfg({MODE_CMP, FN_LOW, 4'b1100}, 3'h1, 10'd5);
        wait_cyc(2);
        chkb("inverted start", 1'b0, timer_out);
        wait_flag(1'b0, 100);
        wait_cyc(2);
        chkb("inverted low", 1'b1, timer_out);
        wait_flag(1'b1, 700);
        chkb("pin on p", 1'b1, timer_out);
        chkb("flag a held", 1'b1, compare_a_req);
        wr(REG_FLAGS, 8'h01);
        chkb("flag a cleared", 1'b0, compare_a_req);
    endtask

    task automatic s_misc;
        cfg({MODE_CMP, FN_TOGGLE, 4'b1001}, 3'h1, 10'd0);
        wait_cyc(4200);
        chkb("zero cmpa flag", 1'b0, compare_a_req);
        chkb("zero cmpa pin", 1'b1, timer_out);
        cfg({MODE_TMR, FN_TOGGLE, 4'b1001}, 3'h1, 10'd5);
        wait_cyc(2);
        chkb("timer mode oe", 1'b0, timer_out_oe);
        wait_flag(1'b0, 100);
        // Capture is not built: counter rests after the run edge, pin and flags stay idle
        cfg({MODE_CAP, 2'b11, 4'b1000}, 3'h1, 10'd5);
        wait_cyc(40);
        chkb("capture oe", 1'b0, timer_out_oe);
        chkb("capture flag a", 1'b0, compare_a_req);
        chkb("capture flag p", 1'b0, compare_p_req);
        rdchk(REG_CNT_LO, 8'h00, "capture count");
    endtask

    task automatic s_pwm(input logic [7:0] c1, input logic [2:0] rp, input logic [9:0] a,
                         input int eh, input int el);
        int hi;
        int lo;
        cfg(c1, rp, a);
        measure(hi, lo);
        chk("pwm high cycles", eh, hi);
        chk("pwm low cycles", el, lo);
    endtask

    task automatic s_pwm_fixed;
        int n;
        n = 0;
        cfg({MODE_PWM, FN_PWM, 4'b1000}, 3'h1, 10'd200);
        repeat (1100) begin
            @(posedge core_clk);
            if (timer_out === 1'b1) n++;
        end
        chk("full duty", 1100, n);
        cfg({MODE_PWM, FN_ACT, 4'b1000}, 3'h1, 10'd32);
        wait_flag(1'b0, 200);
        wait_flag(1'b1, 700);
        chkb("forced active", 1'b1, timer_out);
        cfg({MODE_PWM, FN_INACT, 4'b1000}, 3'h1, 10'd32);
        wait_cyc(4);
        chkb("forced inactive", 1'b0, timer_out);
    endtask

    task automatic s_pulse;
        logic [31:0] v;
        cfg({MODE_PWM, FN_PULSE, 4'b1000}, 3'h1, 10'h12c);
        wait_cyc(2);
        chkb("pulse start", 1'b1, timer_out);
        wait_cyc(1300);
        chkb("pulse end", 1'b0, timer_out);
        chkb("pulse flag a", 1'b1, compare_a_req);
        chkb("pulse flag p", 1'b0, compare_p_req);
        rdchk(REG_CTRL0, 8'h01, "run cleared");
        rdchk(REG_CNT_LO, 8'h2c, "count low");
        rdchk(REG_CNT_HI, 8'h01, "count high");
        ext_clock_pin <= 1'b1;
        wait_cyc(10);
        chkb("pin started", 1'b1, timer_out);
        rdchk(REG_CTRL0, 8'h09, "run by pin");
        ext_clock_pin <= 1'b0;
        wr(REG_CTRL0, 8'h01);
        wait_cyc(2);
        chkb("soft end", 1'b0, timer_out);
        bus(1'b0, REG_CNT_LO, 8'h00, 4'hf);
        v = rdata;
        wait_cyc(20);
        rdchk(REG_CNT_LO, v[7:0], "count held");
    endtask

    initial begin
        srst           = 1'b1;
        avs_address    = 3'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
        ext_clock_pin  = 1'b0;
        rdata          = 32'h0;
        fails          = 0;
        compares       = 0;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        s_regs();
        s_cmp_fn();
        s_cmp_p();
        s_misc();
        s_pwm({MODE_PWM, FN_PWM, 4'b1000}, 3'h1, 10'd32, 128, 384);
        s_pwm({MODE_PWM, FN_PWM, 4'b1000}, 3'h0, 10'd32, 128, 3968);
        s_pwm({MODE_PWM, FN_PWM, 4'b0000}, 3'h1, 10'd32, 384, 128);
        s_pwm({MODE_PWM, FN_PWM, 4'b1100}, 3'h1, 10'd32, 384, 128);
        s_pwm({MODE_PWM, FN_PWM, 4'b1010}, 3'h1, 10'd200, 512, 288);
        s_pwm_fixed();
        s_pulse();
        print_verdict();
    end
endmodule
